// ### dv/cmpp_host_model.sv
// Host controller model: serial command frames and static strap levels.
// Assumes a pull-up on the SDO wire; the bench calls xfer and strap.
`timescale 1ns/100ps
module cmpp_host_model (
  // Clock
  input  wire logic clk_sys,
  // Open-drain output of the device
  input  wire logic sdoOut,
  input  wire logic sdoOe_n,
  // Pins toward the device
  output logic      csPin_n,
  output logic      sckPin,
  output logic      sdiPin,
  output logic      sdoWire,
  // Read-back result, one pulse per read frame
  output logic      rdDone,
  output logic [7:0] rdData
);
  logic strapOn;
  logic strapSdo;

  // Pull-up wins unless the device pulls low; straps drive via a resistor
  assign sdoWire = strapOn ? strapSdo : (!sdoOe_n ? sdoOut : 1'b1);

  initial begin
    {csPin_n, sckPin, sdiPin, strapOn, strapSdo, rdDone} = 6'h20;
    rdData = 8'h00;
  end

  // One frame; ph sets each SCK phase, rises may be short or long
  task automatic xfer(input logic [15:0] word, input int rises, input int ph);
    logic [7:0] got;
    got = 8'h00;
    @(posedge clk_sys);
    csPin_n <= 1'b0;
    for (int i = 0; i < rises; i++) begin
      sdiPin <= (i < 16) ? word[15-i] : ~sdiPin;
      repeat (ph) @(posedge clk_sys);
      if (i >= 8 && i < 16) got = {got[6:0], sdoWire};
      sckPin <= 1'b1;
      repeat (ph) @(posedge clk_sys);
      sckPin <= 1'b0;
    end
    repeat (ph) @(posedge clk_sys);
    csPin_n <= 1'b1;
    sdiPin <= ~sdiPin; // Released line has no pull, so it wanders
    if (word[15] && rises >= 16) begin
      rdData <= got;
      rdDone <= 1'b1;
    end
    repeat (ph) @(posedge clk_sys);
    rdDone <= 1'b0;
  endtask

  // Strap levels {chip select, clock, data in, data out}
  task automatic strap(input logic [3:0] pins);
    @(posedge clk_sys);
    strapOn <= 1'b1;
    {csPin_n, sckPin, sdiPin, strapSdo} <= pins;
  endtask
endmodule

// ### dv/cmpp_top_properties.sv
// Concurrent checks on the pins and outputs of the mode-programming port.
// Assumes straps and samples change on clk_sys; bound at the file foot.
`timescale 1ns/100ps
module cmpp_top_properties
  import cmpp_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        arst_n,
  // Configuration pins
  input wire logic        interfaceSelectPin,
  input wire logic        csPin_n,
  input wire logic        sckPin,
  input wire logic        sdiPin,
  input wire logic        sdoIn,
  input wire logic        sdoOut,
  input wire logic        sdoOe_n,
  // Samples and formatted outputs
  input wire logic        sampleValid,
  input wire logic [15:0] sampleData,
  input wire logic        sampleOvr,
  input wire logic [15:0] dataOut,
  input wire logic        overrangeFlag,
  input wire logic        dataOe_n,
  input wire cmpp_power_t powerState,
  input wire logic        dcsOn,
  input wire logic [1:0]  outMode,
  input wire logic [2:0]  lvdsCurrent,
  input wire logic        termOn
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Straps held long enough to get through the pin filters
  sequence strapSteady;
    (interfaceSelectPin && $stable({csPin_n, sckPin, sdiPin, sdoIn}))[*8];
  endsequence
  // No frame open for a while
  sequence csIdle;
    csPin_n[*8];
  endsequence

  sdo_pull_low_a: assert property (!sdoOe_n |-> !sdoOut)
    else $error("SDO driven high");
  sdo_idle_a: assert property (csIdle |-> sdoOe_n)
    else $error("SDO pulled outside a frame");
  sdo_in_frame_a: assert property ($fell(sdoOe_n) |-> !csPin_n)
    else $error("SDO pull began without chip select");
  data_hold_a: assert property (
    !sampleValid |=> $stable({overrangeFlag, dataOut}))
    else $error("Output word changed without a sample");
  strap_dcs_a: assert property (strapSteady |-> dcsOn == csPin_n)
    else $error("Stabilizer does not follow strap");
  strap_outmode_a: assert property (strapSteady |->
    outMode == {1'b0, sckPin} && lvdsCurrent == CMPP_ILVDS_3P5MA && !termOn)
    else $error("Output mode does not follow strap");
  strap_power_a: assert property (strapSteady |-> powerState ==
    (!sdiPin ? CMPP_NORMAL : (sdoIn ? CMPP_SLEEP : CMPP_NAP)))
    else $error("Power state does not follow straps");
  strap_sdo_off_a: assert property (
    strapSteady |-> sdoOe_n && !dataOe_n)
    else $error("Serial output active in strap mode");
  strap_raw_a: assert property (strapSteady ##0 sampleValid |=>
    {overrangeFlag, dataOut} == $past({sampleOvr, sampleData}))
    else $error("Strap mode sample was altered");
endmodule

bind cmpp_top cmpp_top_properties chk (
  .clk_sys(clk_sys), .arst_n(arst_n),
  .interfaceSelectPin(interfaceSelectPin), .csPin_n(csPin_n),
  .sckPin(sckPin), .sdiPin(sdiPin), .sdoIn(sdoIn), .sdoOut(sdoOut),
  .sdoOe_n(sdoOe_n), .sampleValid(sampleValid), .sampleData(sampleData),
  .sampleOvr(sampleOvr), .dataOut(dataOut), .overrangeFlag(overrangeFlag),
  .dataOe_n(dataOe_n), .powerState(powerState), .dcsOn(dcsOn),
  .outMode(outMode), .lvdsCurrent(lvdsCurrent), .termOn(termOn));

// ### dv/tb_converter_mode_programming_port.sv
// Self-checking bench for the converter mode-programming port.
// Assumes the host model frames commands and resolves the SDO wire.
`timescale 1ns/100ps
module tb_converter_mode_programming_port;
  import cmpp_pkg::*;
  logic        clk_sys, arst_n, interfaceSelectPin, csPin_n, sckPin;
  logic        sdiPin, sdoWire, sdoOut, sdoOe_n, sampleValid, sampleOvr;
  logic        overrangeFlag, outputDataClock, dataOe_n, dcsOn, termOn;
  logic        clkInvert, rdDone, vD, phase, sleepSeen;
  logic [15:0] sampleData, dataOut;
  logic [7:0]  rdData;
  logic [5:0]  fmt;
  logic [2:0]  lvdsCurrent;
  logic [1:0]  outMode, clkPhase;
  cmpp_power_t powerState;
  int          errCount, testsRun;
  logic [16:0] expQ[$];
  logic [7:0]  rdQ[$];

  cmpp_top dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .interfaceSelectPin(interfaceSelectPin), .csPin_n(csPin_n),
    .sckPin(sckPin), .sdiPin(sdiPin), .sdoIn(sdoWire), .sdoOut(sdoOut),
    .sdoOe_n(sdoOe_n), .sampleValid(sampleValid), .sampleData(sampleData),
    .sampleOvr(sampleOvr), .dataOut(dataOut), .overrangeFlag(overrangeFlag),
    .outputDataClock(outputDataClock), .dataOe_n(dataOe_n),
    .powerState(powerState), .dcsOn(dcsOn), .outMode(outMode),
    .lvdsCurrent(lvdsCurrent), .termOn(termOn), .clkPhase(clkPhase),
    .clkInvert(clkInvert));
  cmpp_host_model host (.clk_sys(clk_sys), .sdoOut(sdoOut),
    .sdoOe_n(sdoOe_n), .csPin_n(csPin_n), .sckPin(sckPin), .sdiPin(sdiPin),
    .sdoWire(sdoWire), .rdDone(rdDone), .rdData(rdData));

  // 20 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk_data(input logic [16:0] got, input logic [16:0] exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk_data({9'h000, got}, {9'h000, exp});
  endtask

  // Expected output word; test patterns sit above all formatting
  function automatic logic [16:0] expect_word(logic [15:0] d, logic o,
                                              logic [5:0] f, logic ph);
    logic [15:0] v;
    v = d;
    if (f[0] && !f[2]) v[15] = ~v[15];
    if (f[1]) v[15:1] = v[15:1] ^ {15{v[0]}};
    if (f[2]) v = v ^ CMPP_ODD_MASK;
    case (f[5:3])
      CMPP_TEST_ZEROS:   return 17'h00000;
      CMPP_TEST_ONES:    return 17'h1ffff;
      CMPP_TEST_CHECKER: return ph ? CMPP_CHECKER_B : CMPP_CHECKER_A;
      CMPP_TEST_ALT:     return ph ? 17'h00000 : 17'h1ffff;
      default:           return {o, v};
    endcase
  endfunction

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'b0, a, d}, 16, 6);
    repeat (12) @(posedge clk_sys);
  endtask
  // Read with random bits on the data-in line, which must be ignored
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input int ph);
    rdQ.push_back(e);
    host.xfer({1'b1, a, 8'($urandom())}, 16, ph);
  endtask
  task automatic send(input int n);
    logic [15:0] d;
    logic        o;
    repeat (n) begin
      d = 16'($urandom());
      o = 1'($urandom());
      expQ.push_back(expect_word(d, o, fmt, phase));
      phase = ~phase;
      @(posedge clk_sys);
      sampleValid <= 1'b1;
      sampleData <= d;
      sampleOvr <= o;
      @(posedge clk_sys);
      sampleValid <= 1'b0;
    end
  endtask

  // Output watchers take the oldest expectation as each result appears
  always @(posedge clk_sys) begin
    if (vD && expQ.size() > 0) begin
      chk_data({overrangeFlag, dataOut}, expQ.pop_front());
      chk_byte({7'h00, outputDataClock}, 8'h01);
    end
    vD <= sampleValid;
    if (powerState === CMPP_SLEEP) sleepSeen <= 1'b1;
  end
  always @(posedge rdDone) chk_byte(rdData, rdQ.pop_front());

  task automatic giveVerdict();
    $display("Comparisons %0d, mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard, about twice the expected run
  initial begin
    repeat (90000) @(posedge clk_sys);
    errCount++;
    giveVerdict();
  end

  initial begin
    logic [7:0] r;
    logic [2:0] codes [6];
    codes = '{CMPP_TEST_OFF, CMPP_TEST_ZEROS, CMPP_TEST_ONES,
              CMPP_TEST_CHECKER, CMPP_TEST_ALT, 3'h2};
    {arst_n, interfaceSelectPin, sampleValid, sampleOvr} = 4'h0;
    {vD, phase, sleepSeen, fmt, sampleData} = '0;
    {errCount, testsRun} = '0;
    void'($urandom(32'hfedf));
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    wr(CMPP_ADDR_SOFT_RESET, 8'h80);
    chk_byte({7'h00, sleepSeen}, 8'h01);
    rd(CMPP_ADDR_POWER_DOWN, CMPP_REG_RESET_VAL, 6);
    for (int i = 0; i < 4; i++) begin
      r = {6'($urandom()), 2'(i)};
      wr(CMPP_ADDR_POWER_DOWN, r);
      chk_byte({6'h00, powerState}, (i > 1) ? 8'(i - 1) : 8'h00);
      rd(CMPP_ADDR_POWER_DOWN, r, 6);
    end
    // Timing and output mode fields, then a second reset clears them
    wr(CMPP_ADDR_TIMING, 8'h0b);
    chk_byte({4'h0, clkInvert, clkPhase, dcsOn}, 8'h0b);
    wr(CMPP_ADDR_OUTPUT_MODE, 8'h79);
    chk_byte({1'b0, lvdsCurrent, termOn, 1'b0, outMode}, 8'h79);
    wr(CMPP_ADDR_SOFT_RESET, 8'h80);
    chk_byte({clkInvert, clkPhase, dcsOn, lvdsCurrent, termOn},
             8'h00);
    chk_byte({6'h00, powerState}, 8'h00);
    repeat (41000) @(posedge clk_sys);
    // Short frame dropped, extra clock edges ignored
    host.xfer({1'b0, CMPP_ADDR_POWER_DOWN, 8'h03}, 10, 6);
    repeat (12) @(posedge clk_sys);
    rd(CMPP_ADDR_POWER_DOWN, 8'h00, 6);
    host.xfer({1'b0, CMPP_ADDR_POWER_DOWN, 8'h02}, 20, 6);
    repeat (12) @(posedge clk_sys);
    rd(CMPP_ADDR_POWER_DOWN, 8'h02, 9);
    // Outputs disabled only while the output disable bit is set
    wr(CMPP_ADDR_OUTPUT_MODE, 8'h04);
    chk_byte({7'h00, dataOe_n}, 8'h01);
    wr(CMPP_ADDR_OUTPUT_MODE, 8'h00);
    wr(CMPP_ADDR_POWER_DOWN, 8'h00);
    chk_byte({7'h00, dataOe_n}, 8'h00);
    repeat (100) @(posedge clk_sys);
    rd(CMPP_ADDR_SOFT_RESET, CMPP_READ_NONE, 6);
    rd(7'h55, CMPP_READ_NONE, 6);
    for (int k = 0; k < 6; k++) begin
      fmt = {codes[k], 3'($urandom())};
      wr(CMPP_ADDR_DATA_FORMAT, {2'b00, fmt});
      send(4);
    end
    fmt = 6'h00;
    // Every option left on, so strap mode must bypass all of them
    wr(CMPP_ADDR_DATA_FORMAT, 8'h3f);
    // Strap mode over every pin combination
    interfaceSelectPin <= 1'b1;
    for (int p = 0; p < 16; p++) begin
      host.strap(4'(p));
      repeat (12) @(posedge clk_sys);
      chk_byte({dcsOn, outMode, lvdsCurrent, termOn, 1'b0},
               {p[3], 1'b0, p[2], 5'h00});
      chk_byte({6'h00, powerState},
               {6'h00, p[1] ? (p[0] ? 2'h2 : 2'h1) : 2'h0});
      send(1);
    end
    repeat (4) @(posedge clk_sys);
    giveVerdict();
  end
endmodule

// ### src/cmpp_pkg.sv
// Constants and types of the converter mode-programming port.
// Shared by the top module and by the verification side.
package cmpp_pkg;

  // Serial frame layout
  localparam int         CMPP_FRAME_BITS = 16;
  localparam int         CMPP_ADDR_BITS  = 7;
  localparam int         CMPP_DATA_BITS  = 8;
  localparam logic [4:0] CMPP_FRAME_LAST = 5'h0f;
  localparam logic [4:0] CMPP_ADDR_LAST  = 5'h07;
  localparam logic [4:0] CMPP_FRAME_FULL = 5'h10;
  localparam int         CMPP_RW_POS     = 15;
  localparam int         CMPP_ADDR_LSB   = 8;

  // Register offsets
  localparam logic [6:0] CMPP_ADDR_SOFT_RESET  = 7'h00;
  localparam logic [6:0] CMPP_ADDR_POWER_DOWN  = 7'h01;
  localparam logic [6:0] CMPP_ADDR_TIMING      = 7'h02;
  localparam logic [6:0] CMPP_ADDR_OUTPUT_MODE = 7'h03;
  localparam logic [6:0] CMPP_ADDR_DATA_FORMAT = 7'h04;

  // Reset and read-back values
  localparam logic [7:0] CMPP_REG_RESET_VAL = 8'h00;
  localparam logic [7:0] CMPP_READ_NONE     = 8'h00;

  // Field positions
  localparam int CMPP_SOFT_RESET_BIT = 7;
  localparam int CMPP_PWR_LSB        = 0;
  localparam int CMPP_DCS_BIT        = 0;
  localparam int CMPP_CLKPHASE_LSB   = 1;
  localparam int CMPP_CLKINV_BIT     = 3;
  localparam int CMPP_OUTMODE_LSB    = 0;
  localparam int CMPP_OUTPUT_DISABLE_BIT_BIT     = 2;
  localparam int CMPP_TERMON_BIT     = 3;
  localparam int CMPP_ILVDS_LSB      = 4;
  localparam int CMPP_TWOS_BIT       = 0;
  localparam int CMPP_RAND_BIT       = 1;
  localparam int CMPP_ABP_BIT        = 2;
  localparam int CMPP_TEST_LSB       = 3;

  // Test pattern codes
  localparam logic [2:0] CMPP_TEST_OFF     = 3'h0;
  localparam logic [2:0] CMPP_TEST_ZEROS   = 3'h1;
  localparam logic [2:0] CMPP_TEST_ONES    = 3'h3;
  localparam logic [2:0] CMPP_TEST_CHECKER = 3'h5;
  localparam logic [2:0] CMPP_TEST_ALT     = 3'h7;

  // Power state codes
  localparam logic [1:0] CMPP_PWR_CODE_NORMAL = 2'h0;
  localparam logic [1:0] CMPP_PWR_CODE_NAP    = 2'h2;
  localparam logic [1:0] CMPP_PWR_CODE_SLEEP  = 2'h3;

  // Output mode codes and strap defaults
  localparam logic [1:0] CMPP_OUTMODE_CMOS  = 2'h0;
  localparam logic [1:0] CMPP_OUTMODE_LVDS  = 2'h1;
  localparam logic [2:0] CMPP_ILVDS_3P5MA   = 3'h0;

  // Output patterns, overrange flag in the top bit
  localparam logic [16:0] CMPP_CHECKER_A = 17'h15555;
  localparam logic [16:0] CMPP_CHECKER_B = 17'h0aaaa;
  localparam logic [15:0] CMPP_ODD_MASK  = 16'haaaa;
  localparam int          CMPP_DATA_W    = 16;

  // Length of the sleep pulse after a software reset, in clk_sys cycles
  localparam logic [3:0] CMPP_SOFT_SLEEP_CYC = 4'h4;

  typedef enum logic [1:0] {
    CMPP_NORMAL,
    CMPP_NAP,
    CMPP_SLEEP
  } cmpp_power_t;

  typedef enum logic [1:0] {
    CMPP_SER_IDLE,
    CMPP_SER_XFER,
    CMPP_SER_FULL
  } cmpp_ser_t;

endpackage

// ### src/cmpp_sync.sv
// Three-stage pin synchroniser with a two-stage agreement filter.
// Assumes inputs are asynchronous to clk_sys; output is a clean level.
`timescale 1ns/100ps
module cmpp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  // Pins and filtered levels
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] levelOut
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;

  if (WIDTH < 1) begin : g_chk
    $error("cmpp_sync: WIDTH must be at least one");
  end

  // Capture chain; stage1 feeds only stage2
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // A bit changes only once the last two stages agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        levelOut[i] <= 1'b0;
      end else if (stage2_r[i] == stage3_r[i]) begin
        levelOut[i] <= stage3_r[i];
      end
    end
  end

endmodule

// ### src/cmpp_top.sv
// Mode-programming port of a sampling converter: serial register port,
// static strap mode, output formatting and test patterns.
// Assumes pins are asynchronous to clk_sys and sample data is on clk_sys.
//
// Summary of operation
// - Test modes force all ones, zeros, alternating.
// - Checkerboard alternates fixed pattern and complement.
// - Test pattern overrides all other formatting.
// - Output disable tristates data, flag and clock.
// - Select pin high makes port pins straps.
// - Chip select strap switches duty cycle stabilizer.
// - Clock strap selects CMOS or LVDS output.
// - Data pin pair strap selects power state.
// - Chip select low frames each serial transfer.
// - Sample first sixteen rising clocks, ignore rest.
// - Frame is flag, address, data, MSB first.
// - Flag low writes data to addressed register.
// - Flag high reads back, register unchanged.
// - Serial out only pulls low, open drain.
// - Reset bit clears registers, then self-clears.
// - Software reset briefly forces sleep.
// - Reset register is write-only.
// - Power register low bits select power state.
// - Test field codes off, zeros, ones, patterns.
// - Output disable bit tristates digital outputs.
`timescale 1ns/100ps
module cmpp_top
  import cmpp_pkg::*;
#(
  parameter int DATA_W = CMPP_DATA_W
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  // Configuration pins
  input  wire logic         interfaceSelectPin,
  input  wire logic         csPin_n,
  input  wire logic         sckPin,
  input  wire logic         sdiPin,
  input  wire logic         sdoIn,
  output logic              sdoOut,
  output logic              sdoOe_n,
  // Sample stream from the converter core
  input  wire logic         sampleValid,
  input  wire logic [15:0]  sampleData,
  input  wire logic         sampleOvr,
  // Formatted digital outputs
  output logic [15:0]       dataOut,
  output logic              overrangeFlag,
  output logic              outputDataClock,
  output logic              dataOe_n,
  // Mode settings to the analog and driver sections
  output cmpp_power_t       powerState,
  output logic              dcsOn,
  output logic [1:0]        outMode,
  output logic [2:0]        lvdsCurrent,
  output logic              termOn,
  output logic [1:0]        clkPhase,
  output logic              clkInvert
);

  if (DATA_W != CMPP_DATA_W) begin : g_chk
    $error("cmpp_top: only a 16-bit data path is supported");
  end

  // Filtered pin levels
  logic [4:0]  pinLevel;
  logic        parMode;
  logic        csLvl_n;
  logic        sckLvl;
  logic        sdiLvl;
  logic        sdoLvl;

  // Edge detection and serial engine
  logic        csPrev_r;
  logic        sckPrev_r;
  logic        csFall;
  logic        csRise;
  logic        sckRise;
  cmpp_ser_t   serState_r;
  logic [4:0]  bitCnt_r;
  logic [15:0] shiftIn_r;
  logic [7:0]  readSh_r;
  logic        readAct_r;
  logic [6:0]  frameAddr;

  // Mode registers and software reset
  logic [7:0]  pdReg_r;
  logic [7:0]  timReg_r;
  logic [7:0]  omReg_r;
  logic [7:0]  dfReg_r;
  logic [3:0]  softSleep_r;
  logic        commitWrite;
  logic [6:0]  wrAddr;
  logic [7:0]  wrData;

  // Output formatting
  logic        phase_r;
  logic [2:0]  testCode;
  logic [16:0] fmtWord;
  logic [15:0] fmtData;
  logic        sdoOut_r;
  logic        sdoOe_r_n;

  // Maps a two-bit power code to a state; the unused code stays normal
  function automatic cmpp_power_t decodePower(input logic [1:0] code);
    cmpp_power_t st;
    st = CMPP_NORMAL;
    if (code == CMPP_PWR_CODE_NAP) begin
      st = CMPP_NAP;
    end else if (code == CMPP_PWR_CODE_SLEEP) begin
      st = CMPP_SLEEP;
    end
    return st;
  endfunction

  // Read-back value for an address
  function automatic logic [7:0] readReg(input logic [6:0] addr);
    logic [7:0] val;
    val = CMPP_READ_NONE;
    unique case (addr)
      CMPP_ADDR_POWER_DOWN:  val = pdReg_r;
      CMPP_ADDR_TIMING:      val = timReg_r;
      CMPP_ADDR_OUTPUT_MODE: val = omReg_r;
      CMPP_ADDR_DATA_FORMAT: val = dfReg_r;
      default:               val = CMPP_READ_NONE;
    endcase
    return val;
  endfunction

  // All configuration pins cross into clk_sys through the filter
  cmpp_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .pinIn    ({interfaceSelectPin, csPin_n, sckPin, sdiPin, sdoIn}),
    .levelOut (pinLevel)
  );

  assign parMode = pinLevel[4];
  assign csLvl_n = pinLevel[3];
  assign sckLvl  = pinLevel[2];
  assign sdiLvl  = pinLevel[1];
  assign sdoLvl  = pinLevel[0];

  // Edge history of the filtered serial pins; reset levels match the
  // filter's, so no false frame opens just after reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      csPrev_r  <= 1'b0;
      sckPrev_r <= 1'b0;
    end else begin
      csPrev_r  <= csLvl_n;
      sckPrev_r <= sckLvl;
    end
  end

  assign csFall    = csPrev_r & ~csLvl_n;
  assign csRise    = ~csPrev_r & csLvl_n;
  assign sckRise   = ~sckPrev_r & sckLvl;
  assign frameAddr = {shiftIn_r[5:0], sdiLvl};

  // A write takes effect only when a full frame ends at chip select rise
  assign commitWrite = (serState_r == CMPP_SER_FULL) && csRise &&
                       !shiftIn_r[CMPP_RW_POS];
  assign wrAddr = shiftIn_r[CMPP_RW_POS-1:CMPP_ADDR_LSB];
  assign wrData = shiftIn_r[CMPP_DATA_BITS-1:0];

  // Serial frame engine; strap mode holds it idle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      serState_r <= CMPP_SER_IDLE;
      bitCnt_r   <= 5'h00;
      shiftIn_r  <= 16'h0000;
    end else if (parMode) begin
      serState_r <= CMPP_SER_IDLE;
      bitCnt_r   <= 5'h00;
    end else begin
      unique case (serState_r)
        CMPP_SER_IDLE: begin
          if (csFall) begin
            serState_r <= CMPP_SER_XFER;
            bitCnt_r   <= 5'h00;
          end
        end
        CMPP_SER_XFER: begin
          if (csRise) begin
            serState_r <= CMPP_SER_IDLE;
          end else if (sckRise) begin
            shiftIn_r <= {shiftIn_r[14:0], sdiLvl};
            bitCnt_r  <= bitCnt_r + 5'h01;
            if (bitCnt_r == CMPP_FRAME_LAST) begin
              serState_r <= CMPP_SER_FULL;
            end
          end
        end
        CMPP_SER_FULL: begin
          // Extra clock edges are ignored until the frame closes
          if (csRise) begin
            serState_r <= CMPP_SER_IDLE;
          end
        end
      endcase
    end
  end

  // Read-back shifter: loaded after the address, then one bit per edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      readSh_r  <= 8'h00;
      readAct_r <= 1'b0;
    end else if (parMode || csRise || serState_r != CMPP_SER_XFER) begin
      readAct_r <= 1'b0;
    end else if (sckRise) begin
      if (bitCnt_r == CMPP_ADDR_LAST) begin
        readSh_r  <= readReg(frameAddr);
        readAct_r <= shiftIn_r[6];
      end else if (bitCnt_r == CMPP_FRAME_LAST) begin
        readAct_r <= 1'b0;
      end else begin
        readSh_r <= {readSh_r[6:0], 1'b0};
      end
    end
  end

  // Open drain: the pin is only ever pulled low, never driven high
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sdoOut_r  <= 1'b0;
      sdoOe_r_n <= 1'b1;
    end else begin
      sdoOut_r  <= 1'b0;
      sdoOe_r_n <= ~(readAct_r & ~readSh_r[7] & ~parMode);
    end
  end

  assign sdoOut  = sdoOut_r;
  assign sdoOe_n = sdoOe_r_n;

  // Mode registers; the reset bit is never stored so it reads cleared
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pdReg_r  <= CMPP_REG_RESET_VAL;
      timReg_r <= CMPP_REG_RESET_VAL;
      omReg_r  <= CMPP_REG_RESET_VAL;
      dfReg_r  <= CMPP_REG_RESET_VAL;
    end else if (commitWrite) begin
      unique case (wrAddr)
        CMPP_ADDR_SOFT_RESET: begin
          if (wrData[CMPP_SOFT_RESET_BIT]) begin
            pdReg_r  <= CMPP_REG_RESET_VAL;
            timReg_r <= CMPP_REG_RESET_VAL;
            omReg_r  <= CMPP_REG_RESET_VAL;
            dfReg_r  <= CMPP_REG_RESET_VAL;
          end
        end
        CMPP_ADDR_POWER_DOWN:  pdReg_r  <= wrData;
        CMPP_ADDR_TIMING:      timReg_r <= wrData;
        CMPP_ADDR_OUTPUT_MODE: omReg_r  <= wrData;
        CMPP_ADDR_DATA_FORMAT: dfReg_r  <= wrData;
        default: begin
          // Unmapped addresses take no write
        end
      endcase
    end
  end

  // Sleep pulse that follows a software reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      softSleep_r <= 4'h0;
    end else if (commitWrite && wrAddr == CMPP_ADDR_SOFT_RESET &&
                 wrData[CMPP_SOFT_RESET_BIT]) begin
      softSleep_r <= CMPP_SOFT_SLEEP_CYC;
    end else if (softSleep_r != 4'h0) begin
      softSleep_r <= softSleep_r - 4'h1;
    end
  end

  // Mode outputs come from the straps or from the registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      powerState  <= CMPP_NORMAL;
      dcsOn       <= 1'b0;
      outMode     <= CMPP_OUTMODE_CMOS;
      lvdsCurrent <= CMPP_ILVDS_3P5MA;
      termOn      <= 1'b0;
      clkPhase    <= 2'h0;
      clkInvert   <= 1'b0;
    end else if (parMode) begin
      powerState  <= decodePower({sdiLvl, sdoLvl});
      dcsOn       <= csLvl_n;
      outMode     <= sckLvl ? CMPP_OUTMODE_LVDS
                            : CMPP_OUTMODE_CMOS;
      lvdsCurrent <= CMPP_ILVDS_3P5MA;
      termOn      <= 1'b0;
      clkPhase    <= 2'h0;
      clkInvert   <= 1'b0;
    end else begin
      powerState  <= (softSleep_r != 4'h0) ? CMPP_SLEEP
                   : decodePower(pdReg_r[CMPP_PWR_LSB+:2]);
      dcsOn       <= timReg_r[CMPP_DCS_BIT];
      outMode     <= omReg_r[CMPP_OUTMODE_LSB+:2];
      lvdsCurrent <= omReg_r[CMPP_ILVDS_LSB+:3];
      termOn      <= omReg_r[CMPP_TERMON_BIT];
      clkPhase    <= timReg_r[CMPP_CLKPHASE_LSB+:2];
      clkInvert   <= timReg_r[CMPP_CLKINV_BIT];
    end
  end

  // Normal formatting: coding, randomizer, then odd-bit inversion.
  // Alternate polarity forces offset binary, so it masks the MSB flip.
  always_comb begin
    fmtData = sampleData;
    if (!parMode && dfReg_r[CMPP_TWOS_BIT] && !dfReg_r[CMPP_ABP_BIT]) begin
      fmtData[15] = ~fmtData[15];
    end
    if (!parMode && dfReg_r[CMPP_RAND_BIT]) begin
      fmtData[15:1] = fmtData[15:1] ^ {15{fmtData[0]}};
    end
    if (!parMode && dfReg_r[CMPP_ABP_BIT]) begin
      fmtData = fmtData ^ CMPP_ODD_MASK;
    end
  end

  // Test patterns sit last so they win over every other option
  assign testCode = parMode ? CMPP_TEST_OFF
                            : dfReg_r[CMPP_TEST_LSB+:3];

  always_comb begin
    fmtWord = {sampleOvr, fmtData};
    unique case (testCode)
      CMPP_TEST_ZEROS:   fmtWord = 17'h00000;
      CMPP_TEST_ONES:    fmtWord = 17'h1ffff;
      CMPP_TEST_CHECKER: fmtWord = phase_r ? CMPP_CHECKER_B
                                           : CMPP_CHECKER_A;
      CMPP_TEST_ALT:     fmtWord = phase_r ? 17'h00000
                                           : 17'h1ffff;
      default:           fmtWord = {sampleOvr, fmtData};
    endcase
  end

  // Sample phase for the two alternating patterns
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= 1'b0;
    end else if (sampleValid) begin
      phase_r <= ~phase_r;
    end
  end

  // Output word register, updated once per sample
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dataOut       <= 16'h0000;
      overrangeFlag <= 1'b0;
    end else if (sampleValid) begin
      dataOut       <= fmtWord[15:0];
      overrangeFlag <= fmtWord[16];
    end
  end

  // Output clock marks each new sample; the invert bit flips its sense
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      outputDataClock <= 1'b0;
    end else begin
      outputDataClock <= sampleValid ^ clkInvert;
    end
  end

  // One enable covers data, flag and clock; straps keep them driven.
  // Slow by design, so not meant for sharing a bus at speed.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dataOe_n <= 1'b0;
    end else begin
      dataOe_n <= ~parMode & omReg_r[CMPP_OUTPUT_DISABLE_BIT_BIT];
    end
  end

endmodule
